// ===== core/bldc_pkg.sv
// Constants shared by the commutation output block and its helpers.
// Assumes a 25 MHz clock and a classic Wishbone slave with byte addresses.
package bldc_pkg;

	// Clock rate, kept for reference; no count here is derived from it.
	localparam int unsigned CLK_HZ = 25000000;

	// Register byte offsets.
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATE_OFS = 8'h04;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;

	// Control register fields.
	localparam int RUN_BIT = 0;
	localparam int LEAD_BIT = 1;
	localparam int OVERLAP_BIT = 2;
	localparam int POLARITY_BIT = 3;
	localparam int DIRECTION_BIT = 4;
	localparam int FST_LSB = 5;
	localparam logic [31:0] CTRL_RST = 32'h0000000C;

	// Status register fields.
	localparam int NATURAL_BIT = 0;
	localparam int OC_BIT = 1;
	localparam int STEP_LSB = 2;

	// Interrupt status and mask fields.
	localparam int EV_OC = 0;
	localparam int EV_NATURAL = 1;
	localparam int EV_STALL = 2;
	localparam int EV_COUNT = 3;

	// Forced commutation rate codes.
	localparam logic [1:0] FST_HIGH = 2'h0;
	localparam logic [1:0] FST_MIDDLE = 2'h1;

	// Carrier and step counting.
	localparam int CARRIER_BITS = 8;
	localparam int DUTY_BITS = 6;
	localparam int TIMER_BITS = 19;
	localparam logic [2:0] LAST_STEP = 3'h5;

endpackage

// ===== core/pwm_carrier.sv
// Free-running PWM carrier with duty compare.
// Assumes the duty word is synchronous to the clock.
`timescale 1ns/1ns
module pwm_carrier
	import bldc_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Duty command and carrier output.
	input wire logic [DUTY_BITS-1:0] duty_i,
	output logic pwm_on_o
);

	typedef struct packed {
		logic [CARRIER_BITS-1:0] count;
		logic on;
	} carrier_t;

	carrier_t s;
	carrier_t n;

	always_comb begin
		n = s;
		// The carrier period is 256 clocks.
		n.count = CARRIER_BITS'(s.count + 8'h01);
		n.on = s.count[CARRIER_BITS-1:CARRIER_BITS-DUTY_BITS] < duty_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign pwm_on_o = s.on;

endmodule

// ===== core/step_decode.sv
// Maps a commutation step to the high-side and low-side phase masks.
// Bit 0 is phase U, bit 1 is V, bit 2 is W.
`timescale 1ns/1ns
module step_decode (
	// Step and direction.
	input wire logic [2:0] step_i,
	input wire logic reverse_i,
	// Phase masks.
	output logic [2:0] high_o,
	output logic [2:0] low_o
);

	logic [2:0] fh;
	logic [2:0] fl;

	always_comb begin
		unique case (step_i)
			3'h0: begin fh = 3'h1; fl = 3'h2; end
			3'h1: begin fh = 3'h1; fl = 3'h4; end
			3'h2: begin fh = 3'h2; fl = 3'h4; end
			3'h3: begin fh = 3'h2; fl = 3'h1; end
			3'h4: begin fh = 3'h4; fl = 3'h1; end
			3'h5: begin fh = 3'h4; fl = 3'h2; end
			default: begin fh = 3'h0; fl = 3'h0; end
		endcase
		// Reverse swaps V and W so the order becomes U, W, V.
		high_o = reverse_i ? {fh[1], fh[2], fh[0]} : fh;
		low_o = reverse_i ? {fl[1], fl[2], fl[0]} : fl;
	end

endmodule

// ===== core/bldc_commutation_outputs.sv
// Commutation and gate-drive output logic of a sensorless BLDC controller.
// Assumes synchronous inputs, a classic Wishbone master and an external
// bridge that reads the six phase drives and the duty monitor.
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/1ns

module bldc_commutation_outputs
	import bldc_pkg::*;
#(
	parameter int unsigned FORCED_BASE_CYCLES = 65536
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Motor side inputs.
	input wire logic position_sense_i,
	input wire logic overcurrent_in_i,
	input wire logic [DUTY_BITS-1:0] speed_command_i,
	// Phase drives and monitor.
	output logic phase_u_high_drive_o,
	output logic phase_v_high_drive_o,
	output logic phase_w_high_drive_o,
	output logic phase_u_low_drive_o,
	output logic phase_v_low_drive_o,
	output logic phase_w_low_drive_o,
	output logic duty_monitor_o,
	// Interrupt.
	output logic irq_o
);

	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic run;
		logic lead_angle_select;
		logic overlap_select;
		logic drive_polarity_select;
		logic direction_select;
		logic [1:0] fst;
		logic [EV_COUNT-1:0] irq_stat;
		logic [EV_COUNT-1:0] irq_mask;
		logic irq;
		logic natural;
		logic seen_edge;
		logic pending;
		logic [2:0] step;
		logic [2:0] prev_step;
		logic [TIMER_BITS-1:0] forced_cnt;
		logic [TIMER_BITS-1:0] edge_cnt;
		logic [TIMER_BITS-1:0] interval;
		logic [TIMER_BITS-1:0] delay_cnt;
		logic [TIMER_BITS-1:0] ovl_cnt;
		logic wave_prev;
		logic oc_prev;
		logic [2:0] high_pin;
		logic [2:0] low_pin;
		logic duty;
	} state_t;

	state_t s;
	state_t n;

	logic pwm_on;
	logic [2:0] cur_high;
	logic [2:0] cur_low;
	logic [2:0] old_high;
	logic [2:0] old_low;

	pwm_carrier carrier (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.duty_i(speed_command_i),
		.pwm_on_o(pwm_on)
	);

	step_decode cur_dec (
		.step_i(s.step),
		.reverse_i(s.direction_select),
		.high_o(cur_high),
		.low_o(cur_low)
	);

	step_decode old_dec (
		.step_i(s.prev_step),
		.reverse_i(s.direction_select),
		.high_o(old_high),
		.low_o(old_low)
	);

	always_comb begin
		logic [EV_COUNT-1:0] ev;
		logic [EV_COUNT-1:0] clr;
		logic [TIMER_BITS-1:0] period;
		logic [TIMER_BITS-1:0] ovl_len;
		logic wave_edge;
		logic active;
		logic advance;
		logic drive_ok;
		logic [2:0] hi;
		logic [2:0] lo;
		period = '0;
		ovl_len = '0;
		wave_edge = 1'b0;
		active = 1'b0;
		drive_ok = 1'b0;
		hi = 3'h0;
		lo = 3'h0;
		ev = '0;
		clr = '0;
		advance = 1'b0;
		n = s;
		wave_edge = position_sense_i != s.wave_prev;
		n.wave_prev = position_sense_i;
		n.oc_prev = overcurrent_in_i;
		// Wishbone: answer every access one cycle after the strobe.
		n.ack = 1'b0;
		n.rdat = '0;
		if (wb_cyc_i && wb_stb_i && !s.ack) begin
			n.ack = 1'b1;
			case (wb_adr_i)
				CTRL_OFS: begin
					n.rdat[FST_LSB+1:0] = {s.fst, s.direction_select,
						s.drive_polarity_select, s.overlap_select,
						s.lead_angle_select, s.run};
					if (wb_we_i && wb_sel_i[0]) begin
						n.run = wb_dat_i[RUN_BIT];
						n.lead_angle_select = wb_dat_i[LEAD_BIT];
						n.overlap_select = wb_dat_i[OVERLAP_BIT];
						n.drive_polarity_select = wb_dat_i[POLARITY_BIT];
						n.direction_select = wb_dat_i[DIRECTION_BIT];
						n.fst = wb_dat_i[FST_LSB+1:FST_LSB];
					end
				end
				STATE_OFS: begin
					n.rdat[NATURAL_BIT] = s.natural;
					n.rdat[OC_BIT] = s.oc_prev;
					n.rdat[STEP_LSB+2:STEP_LSB] = s.step;
				end
				IRQ_STAT_OFS: begin
					n.rdat[EV_COUNT-1:0] = s.irq_stat;
					if (wb_we_i && wb_sel_i[0]) begin
						clr = wb_dat_i[EV_COUNT-1:0];
					end
				end
				IRQ_MASK_OFS: begin
					n.rdat[EV_COUNT-1:0] = s.irq_mask;
					if (wb_we_i && wb_sel_i[0]) begin
						n.irq_mask = wb_dat_i[EV_COUNT-1:0];
					end
				end
				default: begin
				end
			endcase
		end
		// Forced rate divides by 6 steps of 2^16, 2^17 or 2^18 clocks.
		if (s.fst == FST_HIGH) begin
			period = TIMER_BITS'(FORCED_BASE_CYCLES);
		end else if (s.fst == FST_MIDDLE) begin
			period = TIMER_BITS'(FORCED_BASE_CYCLES * 2);
		end else begin
			period = TIMER_BITS'(FORCED_BASE_CYCLES * 4);
		end
		// Overlap tracks the lead angle; startup uses an eighth step.
		if (!s.natural) begin
			ovl_len = period >> 3;
		end else if (s.lead_angle_select) begin
			ovl_len = s.interval >> 2;
		end else begin
			ovl_len = s.interval >> 3;
		end
		active = s.run && (speed_command_i != '0);
		if (!active) begin
			n.natural = 1'b0;
			n.seen_edge = 1'b0;
			n.pending = 1'b0;
			n.forced_cnt = '0;
			n.edge_cnt = '0;
			n.ovl_cnt = '0;
		end else begin
			if (s.edge_cnt != '1) begin
				n.edge_cnt = TIMER_BITS'(s.edge_cnt + 19'h00001);
			end
			// Every edge of the majority signal marks 60 degrees.
			if (wave_edge) begin
				// Starting at one makes the count the full edge spacing.
				n.edge_cnt = 19'h00001;
				n.seen_edge = 1'b1;
				n.interval = s.edge_cnt;
			end
			if (!s.natural) begin
				// Forced steps on the timer alone, with no lead.
				if (s.forced_cnt >= period - 19'h00001) begin
					advance = 1'b1;
					n.forced_cnt = '0;
				end else begin
					n.forced_cnt = TIMER_BITS'(s.forced_cnt + 19'h00001);
				end
				// Faster than the forced rate means the back-EMF is usable.
				if (wave_edge && s.seen_edge && s.edge_cnt < period) begin
					n.natural = 1'b1;
					ev[EV_NATURAL] = 1'b1;
				end
			end else begin
				if (wave_edge) begin
					// Delay is 22.5 degrees, or 15 degrees with the lead select set.
					n.pending = 1'b1;
					if (s.lead_angle_select) begin
						n.delay_cnt = s.edge_cnt >> 2;
					end else begin
						n.delay_cnt = TIMER_BITS'((s.edge_cnt >> 2) +
							(s.edge_cnt >> 3));
					end
				end else if (s.pending) begin
					if (s.delay_cnt == '0) begin
						advance = 1'b1;
						n.pending = 1'b0;
					end else begin
						n.delay_cnt = TIMER_BITS'(s.delay_cnt - 19'h00001);
					end
				end
				// Too slow for the forced rate: fall back to startup.
				if (s.edge_cnt >= period) begin
					n.natural = 1'b0;
					n.pending = 1'b0;
					n.seen_edge = 1'b0;
					n.forced_cnt = '0;
					ev[EV_STALL] = 1'b1;
				end
			end
			if (advance) begin
				n.prev_step = s.step;
				n.step = (s.step == LAST_STEP) ? 3'h0 : 3'(s.step + 3'h1);
				// The outgoing pair stays on only when the overlap select is clear.
				n.ovl_cnt = s.overlap_select ? '0 : ovl_len;
			end else if (s.ovl_cnt != '0) begin
				n.ovl_cnt = TIMER_BITS'(s.ovl_cnt - 19'h00001);
			end
		end
		// Phase drives; overcurrent forces all of them inactive.
		drive_ok = active && !overcurrent_in_i;
		hi = cur_high | ((s.ovl_cnt != '0) ? old_high : 3'h0);
		lo = cur_low | ((s.ovl_cnt != '0) ? old_low : 3'h0);
		hi = drive_ok ? (hi & {3{pwm_on}}) : 3'h0;
		// High side is inverted when the select is high.
		n.high_pin = hi ^ {3{s.drive_polarity_select}};
		n.low_pin = drive_ok ? lo : 3'h0;
		n.duty = pwm_on && !overcurrent_in_i;
		if (overcurrent_in_i && !s.oc_prev) begin
			ev[EV_OC] = 1'b1;
		end
		// A new event outranks a clear written in the same cycle.
		n.irq_stat = (s.irq_stat & ~clr) | ev;
		n.irq = |(n.irq_stat & n.irq_mask);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.overlap_select <= CTRL_RST[OVERLAP_BIT];
			s.drive_polarity_select <= CTRL_RST[POLARITY_BIT];
			s.lead_angle_select <= CTRL_RST[LEAD_BIT];
			s.direction_select <= CTRL_RST[DIRECTION_BIT];
			s.fst <= CTRL_RST[FST_LSB+1:FST_LSB];
			s.high_pin <= {3{CTRL_RST[POLARITY_BIT]}};
			// The sense line idles high, so a low here would fake an edge.
			s.wave_prev <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign wb_dat_o = s.rdat;
	assign wb_ack_o = s.ack;
	assign phase_u_high_drive_o = s.high_pin[0];
	assign phase_v_high_drive_o = s.high_pin[1];
	assign phase_w_high_drive_o = s.high_pin[2];
	assign phase_u_low_drive_o = s.low_pin[0];
	assign phase_v_low_drive_o = s.low_pin[1];
	assign phase_w_low_drive_o = s.low_pin[2];
	assign duty_monitor_o = s.duty;
	assign irq_o = s.irq;

endmodule

// ===== bench/bldc_commutation_outputs_monitor.sv
// Checker for the commutation output block, bound to its top ports.
// Assumes speed is held steady while carrier periods are judged.
`timescale 1ns/1ns
module bldc_commutation_outputs_monitor
	import bldc_pkg::*;
(
	// Clock, reset and bus.
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Motor side.
	input wire logic overcurrent_in_i,
	input wire logic [DUTY_BITS-1:0] speed_command_i,
	input wire logic phase_u_high_drive_o,
	input wire logic phase_v_high_drive_o,
	input wire logic phase_w_high_drive_o,
	input wire logic phase_u_low_drive_o,
	input wire logic phase_v_low_drive_o,
	input wire logic phase_w_low_drive_o,
	input wire logic duty_monitor_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [2:0] lows;
	logic [DUTY_BITS-1:0] spd_reg;
	logic [9:0] quiet_reg;
	assign lows = {phase_w_low_drive_o, phase_v_low_drive_o,
		phase_u_low_drive_o};
	// A speed change restarts the count, since the carrier phase may jump.
	always_ff @(posedge clk_i) begin
		spd_reg <= speed_command_i;
		if (rst_i || overcurrent_in_i || spd_reg != speed_command_i) begin
			quiet_reg <= 10'h000;
		end else if (quiet_reg != 10'h3FF) begin
			quiet_reg <= quiet_reg + 10'h001;
		end
	end
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	AST_ACK_REQ: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
		wb_ack_o) else $error("request not acknowledged next cycle");
	AST_DAT_ZERO: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack cycle");
	AST_OC_LOW: assert property (overcurrent_in_i [*2] |=> lows == 3'h0)
		else $error("low drive on during overcurrent");
	AST_OC_HIGH: assert property (overcurrent_in_i [*2] |=>
		phase_u_high_drive_o == phase_v_high_drive_o &&
		phase_v_high_drive_o == phase_w_high_drive_o)
		else $error("high drive on during overcurrent");
	AST_OC_DUTY: assert property (overcurrent_in_i [*2] |=> !duty_monitor_o)
		else $error("duty monitor ignores overcurrent");
	AST_SPEED_ZERO: assert property ((speed_command_i == '0) [*2] |=>
		lows == 3'h0 && !duty_monitor_o) else $error("drive at zero speed");
	AST_PWM_PERIOD: assert property ($rose(duty_monitor_o) &&
		quiet_reg > 10'h130 |-> $past(duty_monitor_o, 256) &&
		!$past(duty_monitor_o, 257)) else $error("carrier period wrong");
endmodule

// ===== bench/motor_bridge_model.sv
// Stand-in for the bridge and motor: makes the majority position signal.
// Assumes the bench sets the edge spacing in clocks.
`timescale 1ns/1ns
module motor_bridge_model (
	// Clock and control.
	input wire logic clk_i,
	input wire logic spin_i,
	input wire logic [7:0] gap_i,
	// Position signal.
	output logic position_o
);
	logic [7:0] cnt_reg;
	logic pos_reg;
	// A stopped motor leaves the sense line at its pull-up level.
	always_ff @(posedge clk_i) begin
		if (!spin_i) begin
			cnt_reg <= 8'h00;
			pos_reg <= 1'h1;
		end else if (cnt_reg == gap_i - 8'h01) begin
			cnt_reg <= 8'h00;
			pos_reg <= !pos_reg;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end
	assign position_o = pos_reg;
endmodule

// ===== bench/bldc_commutation_outputs_tb.sv
// Self-checking bench for the commutation output block.
// Assumes a 25 MHz clock and a forced step base shortened to 64 clocks.
`timescale 1ns/1ns
module bldc_commutation_outputs_tb;
	import bldc_pkg::*;
	localparam int BASE = 64;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic c = 1'h0;
	logic s = 1'h0;
	logic we = 1'h0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0;
	logic [31:0] rd;
	logic [31:0] dat;
	logic ack, pos, duty, irq;
	logic oc = 1'h0;
	logic spin = 1'h0;
	logic [7:0] gap = 8'h28;
	logic [5:0] spd = 6'h00;
	wire [2:0] hi, lo;
	int n_fail = 0;
	int checks_done = 0;
	always #20 clk_i = ~clk_i;
	bldc_commutation_outputs #(
		.FORCED_BASE_CYCLES(BASE)
	) u_bldc_commutation_outputs (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(c), .wb_stb_i(s),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd),
		.wb_dat_o(dat), .wb_ack_o(ack), .position_sense_i(pos),
		.overcurrent_in_i(oc), .speed_command_i(spd),
		.phase_u_high_drive_o(hi[0]), .phase_v_high_drive_o(hi[1]),
		.phase_w_high_drive_o(hi[2]), .phase_u_low_drive_o(lo[0]),
		.phase_v_low_drive_o(lo[1]), .phase_w_low_drive_o(lo[2]),
		.duty_monitor_o(duty), .irq_o(irq));
	motor_bridge_model u_motor_bridge_model (.clk_i(clk_i), .spin_i(spin),
		.gap_i(gap), .position_o(pos));
	task automatic finish_test;
		$display("checks %0d errors %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		c <= 1'h1;
		s <= 1'h1;
		we <= w;
		adr <= a;
		wd <= d;
		do @(posedge clk_i); while (ack !== 1'h1);
		rd = dat;
		c <= 1'h0;
		s <= 1'h0;
	endtask
	task automatic t_reset;
		chk("idle high", 3'h7, hi);
		chk("idle low", 3'h0, lo);
		wb(1'h0, CTRL_OFS, 32'h0);
		chk("ctrl", CTRL_RST, rd);
		wb(1'h1, 8'h10, 32'hFFFFFFFF);
		wb(1'h0, 8'h10, 32'h0);
		chk("unmapped", 32'h0, rd);
	endtask
	// One full cycle of six steps is judged, so a step that is a clock long
	// or short, or out of order, shows up.
	task automatic t_forced(input logic [1:0] f, input logic d,
		input logic p, input logic ov);
		logic [2:0] l0, nw, st, hm;
		logic [2:0] pl[6], ph[6];
		int per, nd, n2;
		per = BASE << ((f == 2'h3) ? 2 : f);
		if (d) begin
			pl = '{4, 2, 2, 1, 1, 4};
			ph = '{1, 1, 4, 4, 2, 2};
		end else begin
			pl = '{2, 4, 4, 1, 1, 2};
			ph = '{1, 1, 2, 2, 4, 4};
		end
		nd = 0;
		n2 = 0;
		spd <= 6'h3F;
		wb(1'h1, CTRL_OFS, {25'h0, f, d, p, !ov, 2'h1});
		// Let a new direction reach the pins so it is not taken for a step.
		repeat (2) @(posedge clk_i);
		do begin
			l0 = lo;
			@(posedge clk_i);
		end while (l0 == 3'h0 || (lo & ~l0) == 3'h0);
		nw = lo & ~l0;
		st = (nw == pl[1]) ? 3'h1 : (nw == pl[3]) ? 3'h3 : 3'h5;
		for (int i = 0; i < 6 * per; i++) begin
			if (i > 0 && i % per == 0) st = (st == 3'h5) ? 3'h0 : st + 3'h1;
			if ($countones(lo) == 2) n2++;
			else if (lo !== pl[st]) nd++;
			hm = ph[st] | (ov ? ph[(st == 3'h0) ? 3'h5 : st - 3'h1] : 3'h0);
			if (((hi ^ {3{p}}) & ~hm) != 3'h0) nd++;
			@(posedge clk_i);
		end
		chk("step pattern", 0, nd);
		chk("overlap", ov ? 3 * (per >> 3) : 0, n2);
	endtask
	task automatic t_duty(input logic [5:0] sp);
		int h = 0;
		int p = 0;
		spd <= 6'h00;
		repeat (3) @(posedge clk_i);
		chk("speed off low", 3'h0, lo);
		chk("speed off duty", 1'h0, duty);
		spd <= sp;
		repeat (300) @(posedge clk_i);
		while (duty !== 1'h0) @(posedge clk_i);
		while (duty !== 1'h1) @(posedge clk_i);
		while (duty === 1'h1) begin
			@(posedge clk_i);
			h++;
		end
		p = h;
		while (duty !== 1'h1) begin
			@(posedge clk_i);
			p++;
		end
		chk("duty high", 4 * sp, h);
		chk("carrier", 256, p);
	endtask
	task automatic t_oc;
		for (int m = 1; m >= 0; m--) begin
			wb(1'h1, IRQ_MASK_OFS, m);
			oc <= 1'h1;
			repeat (3) @(posedge clk_i);
			chk("oc low", 3'h0, lo);
			chk("oc high", 3'h7, hi);
			chk("oc duty", 1'h0, duty);
			chk("irq", m, irq);
			wb(1'h0, IRQ_STAT_OFS, 32'h0);
			chk("oc event", 1'h1, rd[EV_OC]);
			wb(1'h1, IRQ_STAT_OFS, 32'h1);
			oc <= 1'h0;
			repeat (2) @(posedge clk_i);
			chk("irq clear", 1'h0, irq);
		end
	endtask
	task automatic t_nat;
		int dl[2];
		logic p0;
		logic [2:0] l0;
		spin <= 1'h1;
		for (int l = 0; l < 2; l++) begin
			wb(1'h1, CTRL_OFS, {25'h0, 4'h0, 1'h1, l[0], 1'h1});
			repeat (400) @(posedge clk_i);
			p0 = pos;
			while (pos === p0) @(posedge clk_i);
			l0 = lo;
			dl[l] = 0;
			while (lo === l0) begin
				@(posedge clk_i);
				dl[l]++;
			end
		end
		wb(1'h0, STATE_OFS, 32'h0);
		chk("natural", 1'h1, rd[NATURAL_BIT]);
		chk("lead diff", 5, dl[0] % 40 - dl[1] % 40);
		spin <= 1'h0;
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'h0;
		t_reset;
		t_forced(2'h0, 1'h0, 1'h0, 1'h0);
		t_forced(2'h1, 1'h1, 1'h0, 1'h0);
		t_forced(2'h2, 1'h0, 1'h1, 1'h1);
		t_forced(2'h3, 1'h1, 1'h1, 1'h1);
		t_oc;
		t_duty(6'h0A);
		t_duty(6'h3F);
		t_nat;
		finish_test;
	end
	initial begin
		#(40 * 40000);
		n_fail++;
		finish_test;
	end
endmodule
bind bldc_commutation_outputs bldc_commutation_outputs_monitor
	u_bldc_commutation_outputs_monitor (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .overcurrent_in_i(overcurrent_in_i),
	.speed_command_i(speed_command_i),
	.phase_u_high_drive_o(phase_u_high_drive_o),
	.phase_v_high_drive_o(phase_v_high_drive_o),
	.phase_w_high_drive_o(phase_w_high_drive_o),
	.phase_u_low_drive_o(phase_u_low_drive_o),
	.phase_v_low_drive_o(phase_v_low_drive_o),
	.phase_w_low_drive_o(phase_w_low_drive_o),
	.duty_monitor_o(duty_monitor_o));
